// File: shared/acs_pkg.sv
// constants, register map and state codes of the adc conversion sequencer
package acs_pkg;
   // timing: least conversion time per channel, rounded up to cycles
   localparam int CLK_MHZ  = 200;
   localparam int CONV_NS  = 7000;
   localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int BIT_CYC  = (CONV_CYC + 11) / 12;
   localparam int SAMP_CYC = 2 * BIT_CYC;
   localparam logic [7:0] BIT_LD  = 8'(BIT_CYC - 1);
   localparam logic [7:0] SAMP_LD = 8'(SAMP_CYC - 1);
   // register byte addresses
   localparam logic [7:0] A_AEN = 8'h1d;
   localparam logic [7:0] A_CSL = 8'h2c;
   localparam logic [7:0] A_CSH = 8'h2d;
   localparam logic [7:0] A_RL  = 8'h2e;
   localparam logic [7:0] A_RH  = 8'h2f;
   localparam logic [7:0] A_IST = 8'h38;
   localparam logic [7:0] A_IMK = 8'h39;
   localparam logic [7:0] A_CFG = 8'h3a;
   // control/status high fields
   localparam int F_BUSY = 7;
   localparam int F_INT  = 6;
   localparam int F_INTE = 5;
   localparam int F_PAUS = 4;
   localparam int F_STS  = 2;
   localparam int F_STRT = 1;
   // control/status low fields
   localparam int F_MD  = 6;
   localparam int F_ANS = 3;
   localparam int F_ANE = 0;
   // config and interrupt status fields
   localparam int F_RES8  = 0;
   localparam int ST_DONE = 0;
   localparam int ST_PASS = 1;
   // codes
   localparam logic [1:0] MD_CONT  = 2'h2;
   localparam logic [1:0] MD_PAUSE = 2'h3;
   localparam logic [1:0] STS_SW   = 2'h0;
   localparam logic [1:0] STS_EXT  = 2'h1;
   localparam logic [1:0] STS_TMR  = 2'h2;
   localparam logic [3:0] AEN_RST  = 4'hf;
   localparam logic [5:0] IRQ_VEC  = 6'h21;
   localparam logic [3:0] ICR_IDX  = 4'hb;
   localparam logic [3:0] MSB_IDX  = 4'h9;
   localparam logic [3:0] LSB10    = 4'h0;
   localparam logic [3:0] LSB8     = 4'h2;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SAMP = 4'b0010,
      S_CONV = 4'b0100,
      S_WAIT = 4'b1000
   } acs_state_type;
endpackage

// File: rtl/acs_sequencer.sv
// four-channel successive-approximation adc sequencer with register port
`timescale 1ns/1ps
module acs_sequencer (
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic [7:0]          addr,
   input  wire logic [7:0]          wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic      [7:0]          rdata,
   input  wire logic                comp,
   input  wire logic                ext_trig_n,
   input  wire logic                tmr_out,
   input  wire logic                xfer_clr,
   output logic      [1:0]          ch_sel,
   output logic                     samp,
   output logic      [9:0]          dac,
   output logic      [3:0]          ain_en,
   output logic                     adc_req,
   output logic      [5:0]          irq_vec,
   output logic      [3:0]          icr_idx,
   output logic                     irq
);
   import acs_pkg::*;

   acs_state_type st_r, st_nxt;
   logic [1:0] md_r, ans_r, ane_r, sts_r, cur_r, cur_nxt;
   logic       inte_r, int_r, res8_r;
   logic [3:0] aen_r;
   logic [9:0] sar_r, res_r;
   logic [3:0] bit_r;
   logic [7:0] cnt_r;
   logic [1:0] ist_r, imk_r;
   logic       cs_m_r, cs_s_r, et_m_r, et_s_r, et_d_r, tm_d_r;

   // pin synchronisers; external-trigger edge logic reads only the second stage onward, timer edge reads the raw tmr_out pin
   always_ff @(posedge mclk) begin
      cs_m_r <= comp;
      cs_s_r <= cs_m_r;
      et_m_r <= ext_trig_n;
      et_s_r <= et_m_r;
      et_d_r <= et_s_r;
      tm_d_r <= tmr_out;
   end

   // register decode and trigger selection
   wire wr_csl  = wr && addr == A_CSL;
   wire wr_csh  = wr && addr == A_CSH;
   wire rd_ist  = rd && addr == A_IST;
   wire ext_ev  = et_d_r && !et_s_r;
   wire tmr_ev  = tmr_out && !tm_d_r;
   wire sw_ev   = wr_csh && wdata[F_STRT];
   wire hw_ev   = (sts_r == STS_EXT && ext_ev) ||
                  (sts_r == STS_TMR && tmr_ev) ||
                  (sts_r == MD_PAUSE && (ext_ev || tmr_ev));
   wire start   = sw_ev || hw_ev;
   wire stop    = wr_csh && !wdata[F_BUSY] && st_r != S_IDLE;
   wire busy    = st_r != S_IDLE;
   // 8-bit mode still walks all ten steps so the 7 us floor holds
   wire cnt_end = cnt_r == 8'h00;
   wire done    = st_r == S_CONV && cnt_end && bit_r == LSB10;
   wire last    = cur_r == ane_r;
   wire [9:0] bm    = 10'h001 << bit_r;
   wire [9:0] keep  = cs_s_r ? sar_r : (sar_r & ~bm);
   wire [9:0] rnew  = res8_r ? {2'b00, keep[9:2]} : keep;

   // sequence: next channel and next state
   always_comb begin
      st_nxt  = st_r;
      cur_nxt = cur_r;
      unique case (st_r)
         S_IDLE: begin
            if (start) begin
               st_nxt  = S_SAMP;
               cur_nxt = ans_r;
            end
         end
         S_SAMP: begin
            if (cnt_end)
               st_nxt = S_CONV;
         end
         S_CONV: begin
            if (done) begin
               cur_nxt = last ? ans_r : cur_r + 2'h1;
               if (md_r == MD_PAUSE)
                  st_nxt = S_WAIT;
               else if (md_r == MD_CONT || !last)
                  st_nxt = S_SAMP;
               else
                  st_nxt = S_IDLE;
            end
         end
         S_WAIT: begin
            if (start)
               st_nxt = S_SAMP;
         end
      endcase
      if (stop)
         st_nxt = S_IDLE;
   end

   // state, channel and converter timing
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r  <= S_IDLE;
         cur_r <= 2'h0;
         cnt_r <= 8'h00;
         bit_r <= MSB_IDX;
         sar_r <= 10'h000;
      end else begin
         st_r  <= st_nxt;
         cur_r <= cur_nxt;
         if (st_nxt == S_SAMP && st_r != S_SAMP) begin
            cnt_r <= SAMP_LD;
         end else if (st_r == S_SAMP && cnt_end) begin
            cnt_r <= BIT_LD;
            bit_r <= MSB_IDX;
            sar_r <= 10'h200;
         end else if (st_r == S_CONV) begin
            cnt_r <= cnt_end ? BIT_LD : cnt_r - 8'h01;
            if (cnt_end) begin
               sar_r <= keep | (bm >> 1);
               bit_r <= bit_r - 4'h1;
            end
         end else begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end

   // software registers; a hardware set wins over any clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         md_r   <= 2'h0;
         ans_r  <= 2'h0;
         ane_r  <= 2'h0;
         sts_r  <= STS_SW;
         inte_r <= 1'b0;
         int_r  <= 1'b0;
         res8_r <= 1'b0;
         aen_r  <= AEN_RST;
         imk_r  <= 2'h0;
         ist_r  <= 2'h0;
         res_r  <= 10'h000;
      end else begin
         if (wr_csl) begin
            md_r  <= wdata[F_MD +: 2];
            ans_r <= wdata[F_ANS +: 2];
            ane_r <= wdata[F_ANE +: 2];
         end
         if (wr_csh) begin
            sts_r  <= wdata[F_STS +: 2];
            inte_r <= wdata[F_INTE];
         end
         if (wr && addr == A_CFG)
            res8_r <= wdata[F_RES8];
         if (wr && addr == A_AEN)
            aen_r <= wdata[3:0];
         if (wr && addr == A_IMK)
            imk_r <= wdata[1:0];
         if (done) begin
            res_r <= rnew;
            int_r <= 1'b1;
         end else if (xfer_clr || (wr_csh && !wdata[F_INT])) begin
            int_r <= 1'b0;
         end
         ist_r[ST_DONE] <= done || (ist_r[ST_DONE] && !rd_ist);
         ist_r[ST_PASS] <= (done && last) ||
                           (ist_r[ST_PASS] && !rd_ist);
      end
   end

   // read data mux
   wire [7:0] csh_v = {busy, int_r, inte_r, st_r == S_WAIT,
                       sts_r, 2'b00};
   wire [7:0] csl_v = {md_r, 1'b0, ans_r, 1'b0, ane_r};
   wire [7:0] rd_v  = addr == A_CSH ? csh_v :
                      addr == A_CSL ? csl_v :
                      addr == A_RL  ? res_r[7:0] :
                      addr == A_RH  ? {6'h00, res_r[9:8]} :
                      addr == A_AEN ? {4'h0, aen_r} :
                      addr == A_IST ? {6'h00, ist_r} :
                      addr == A_IMK ? {6'h00, imk_r} :
                      addr == A_CFG ? {7'h00, res8_r} : 8'h00;

   // registered outputs; the request drives both the cpu and transfer
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata   <= 8'h00;
         ch_sel  <= 2'h0;
         samp    <= 1'b0;
         dac     <= 10'h000;
         ain_en  <= AEN_RST;
         adc_req <= 1'b0;
         irq_vec <= IRQ_VEC;
         icr_idx <= ICR_IDX;
         irq     <= 1'b0;
      end else begin
         rdata   <= rd ? rd_v : 8'h00;
         ch_sel  <= cur_r;
         samp    <= st_r == S_SAMP;
         dac     <= sar_r;
         ain_en  <= aen_r;
         adc_req <= int_r && inte_r;
         irq_vec <= IRQ_VEC;
         icr_idx <= ICR_IDX;
         irq     <= |(ist_r & imk_r);
      end
   end

   // helper: cycles since the channel began sampling
   logic [11:0] len_r;
   always_ff @(posedge mclk) begin
      if (rst || st_r == S_IDLE || st_r == S_WAIT || done)
         len_r <= 12'h000;
      else
         len_r <= len_r + 12'h001;
   end

   localparam int CONV_MIN = CONV_CYC;

   property p_conv_len;
      @(posedge mclk) disable iff (rst) done |-> len_r >= CONV_MIN;
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion shorter than minimum");

   property p_chsel;
      @(posedge mclk) disable iff (rst)
         st_r == S_SAMP |=> ch_sel == $past(cur_r);
   endproperty
   a_chsel: assert property (p_chsel)
      else $error("channel select not following channel");

   sequence s_pass_end;
      done && last && !stop;
   endsequence

   property p_oneshot;
      @(posedge mclk) disable iff (rst)
         s_pass_end ##0 (md_r[1] == 1'b0) |=> st_r == S_IDLE ##1 !samp;
   endproperty
   a_oneshot: assert property (p_oneshot)
      else $error("one-shot did not stop");

   property p_cont;
      @(posedge mclk) disable iff (rst)
         s_pass_end ##0 (md_r == MD_CONT)
         |=> st_r == S_SAMP && cur_r == $past(ans_r);
   endproperty
   a_cont: assert property (p_cont)
      else $error("continuous mode did not restart");

   property p_pause;
      @(posedge mclk) disable iff (rst)
         done && md_r == MD_PAUSE && !stop |=> st_r == S_WAIT;
   endproperty
   a_pause: assert property (p_pause)
      else $error("pause mode did not wait");

   property p_scan;
      @(posedge mclk) disable iff (rst)
         done && !last && !stop |=> cur_r == $past(cur_r) + 2'h1;
   endproperty
   a_scan: assert property (p_scan)
      else $error("scan skipped a channel");

   property p_req;
      @(posedge mclk) disable iff (rst)
         done && inte_r && !wr_csh |-> ##2 adc_req;
   endproperty
   a_req: assert property (p_req)
      else $error("completion request missing");

   property p_ext;
      @(posedge mclk) disable iff (rst)
         st_r == S_IDLE && ext_ev && sts_r == STS_EXT && !stop
         |=> st_r == S_SAMP;
   endproperty
   a_ext: assert property (p_ext)
      else $error("external trigger ignored");

   property p_xclr;
      @(posedge mclk) disable iff (rst) xfer_clr && !done |=> !int_r;
   endproperty
   a_xclr: assert property (p_xclr)
      else $error("transfer clear did not clear flag");

   property p_rh;
      @(posedge mclk) disable iff (rst)
         rd && addr == A_RH |=> rdata[7:2] == 6'h00;
   endproperty
   a_rh: assert property (p_rh)
      else $error("result upper bits not zero");

endmodule

// File: bench/acs_analog_model.sv
// analog input side: four channel voltages seen through the comparator
`timescale 1ns/1ps
module acs_analog_model (
   input  wire logic [3:0][9:0] vin,
   input  wire logic [1:0]      ch_sel,
   input  wire logic [9:0]      dac,
   output logic                 comp
);
   // ideal comparator; no settling delay, so it answers at once
   assign comp = (vin[ch_sel] >= dac);
endmodule

// File: bench/tb.sv
// self-checking bench of the adc conversion sequencer
`timescale 1ns/1ps
module tb;
   import acs_pkg::*;
   logic             mclk       = 1'b0;
   logic             rst        = 1'b1;
   logic [7:0]       addr       = 8'h00;
   logic [7:0]       wdata      = 8'h00;
   logic             wr         = 1'b0;
   logic             rd         = 1'b0;
   logic             ext_trig_n = 1'b1;
   logic             tmr_out    = 1'b0;
   logic             xfer_clr   = 1'b0;
   logic [3:0][9:0]  vin        = '0;
   logic [7:0]       rdata;
   logic             comp;
   logic [1:0]       ch_sel;
   logic             samp;
   logic [9:0]       dac;
   logic [3:0]       ain_en;
   logic             adc_req;
   logic [5:0]       irq_vec;
   logic [3:0]       icr_idx;
   logic             irq;
   logic [7:0]       r;
   int               n;
   int               n_mismatch = 0;
   int               checks     = 0;
   int               cyc        = 0;

   // design and the analog side facing it
   acs_sequencer u_acs_sequencer (.mclk, .rst, .addr, .wdata, .wr, .rd,
      .rdata, .comp, .ext_trig_n, .tmr_out, .xfer_clr, .ch_sel, .samp,
      .dac, .ain_en, .adc_req, .irq_vec, .icr_idx, .irq);
   acs_analog_model u_acs_analog_model (.vin, .ch_sel, .dac, .comp);

   // free-running machine clock
   always #2.5 mclk = ~mclk;

   task automatic complete_run();
      if (n_mismatch == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // cycle ceiling cuts a hang short
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic chk(input string nm, input logic [15:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1 r = rdata;
   endtask

   // bounded wait for the completion request
   task automatic wait_req();
      n = 0;
      while (adc_req !== 1'b1 && n < 4000) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("adc_req", adc_req, 1'b1);
   endtask

   // transfer-done pulse must drop the request with no stop
   task automatic clr_int();
      @(posedge mclk);
      xfer_clr <= 1'b1;
      @(posedge mclk);
      xfer_clr <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("adc_req", adc_req, 1'b0);
   endtask

   function automatic logic [15:0] exp_res(input logic [9:0] v,
                                           input logic b8);
      return b8 ? {8'h00, v[9:2]} : {6'h00, v};
   endfunction

   // ch is the channel converted, nx the channel selected after it
   task automatic chk_res(input int ch, nx, input logic b8);
      logic [7:0] lo;
      rd_reg(A_RL);
      lo = r;
      rd_reg(A_RH);
      chk("ch_sel", 16'(ch_sel), 16'(nx));
      chk("result", {r, lo}, exp_res(vin[ch], b8));
   endtask

   initial begin
      void'($urandom(32'h521f));
      for (int i = 0; i < 4; i++)
         vin[i] = 10'($urandom);
      vin[3] = 10'h3ff;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1 chk("ain_en", ain_en, AEN_RST);
      chk("irq_vec", irq_vec, 6'h21);
      chk("icr_idx", icr_idx, 4'hb);
      rd_reg(A_AEN);
      chk("aen_rd", r, 8'h0f);
      rd_reg(8'h00);
      chk("unmapped", r, 8'h00);
      wr_reg(A_AEN, 8'h05);
      rd_reg(A_AEN);
      chk("ain_en", ain_en, 4'h5);
      chk("aen_rd", r, 8'h05);
      wr_reg(A_AEN, 8'h0f);
      // one-shot channel 2, software start, done bit unmasked
      wr_reg(A_IMK, 8'h01);
      wr_reg(A_CSL, 8'h12);
      wr_reg(A_CSH, 8'h22);
      wait_req();
      chk("conv_time", n >= 1400, 1'b1);
      chk("irq", irq, 1'b1);
      chk_res(2, 2, 1'b0);
      rd_reg(A_IST);
      chk("st_done", r[ST_DONE], 1'b1);
      repeat (3) @(posedge mclk);
      #1 chk("irq", irq, 1'b0);
      clr_int();
      repeat (1500) @(posedge mclk);
      rd_reg(A_CSH);
      chk("busy", r[F_BUSY], 1'b0);
      chk("adc_req", adc_req, 1'b0);
      // trial code settles on the converted value and is left there
      chk("dac", dac, vin[2]);
      // pause mode scan 1..3, external falling-edge starts
      wr_reg(A_CSL, 8'hcb);
      wr_reg(A_CSH, 8'h24);
      for (int c = 1; c < 4; c++) begin
         @(posedge mclk);
         ext_trig_n <= 1'b0;
         repeat (4) @(posedge mclk);
         ext_trig_n <= 1'b1;
         wait_req();
         chk_res(c, (c == 3) ? 1 : c + 1, 1'b0);
         clr_int();
         if (c < 3) begin
            repeat (1500) @(posedge mclk);
            rd_reg(A_CSH);
            chk("paused", r[F_PAUS], 1'b1);
            chk("adc_req", adc_req, 1'b0);
         end
      end
      wr_reg(A_CSH, 8'h00);
      // continuous channel 0, timer rising-edge start, input moves
      wr_reg(A_CSL, 8'h80);
      wr_reg(A_CSH, 8'h28);
      @(posedge mclk);
      tmr_out <= 1'b1;
      @(posedge mclk);
      tmr_out <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         wait_req();
         chk_res(0, 0, 1'b0);
         vin[0] = 10'($urandom);
         clr_int();
      end
      wr_reg(A_CSH, 8'h00);
      repeat (1500) @(posedge mclk);
      rd_reg(A_CSH);
      chk("busy", r[F_BUSY], 1'b0);
      // 8-bit resolution on full-scale channel 3
      wr_reg(A_CFG, 8'h01);
      wr_reg(A_CSL, 8'h1b);
      wr_reg(A_CSH, 8'h22);
      repeat (2) @(posedge mclk);
      #1 chk("samp", samp, 1'b1);
      chk("ch_sel", ch_sel, 2'h3);
      wait_req();
      chk_res(3, 3, 1'b1);
      complete_run();
   end
endmodule
